//--- core/aeb_defs.svh
// Offsets, field positions, reset values and cycle counts of the execution unit
// Assumes byte addressing on a 32-bit register bus
`ifndef AEB_DEFS_SVH
`define AEB_DEFS_SVH
`define AEB_OFF_CTRL    8'h00
`define AEB_OFF_OPND    8'h04
`define AEB_OFF_ZPTR    8'h08
`define AEB_OFF_PC      8'h0C
`define AEB_OFF_FLAGS   8'h10
`define AEB_OFF_STAT    8'h14
`define AEB_CTRL_OP     4:0
`define AEB_CTRL_SEL    10:8
`define AEB_CTRL_TWO    12
`define AEB_CTRL_K      22:16
`define AEB_OPND_RD     7:0
`define AEB_OPND_RR     15:8
`define AEB_OPND_IO     23:16
`define AEB_STAT_BUSY   0
`define AEB_STAT_TAKEN  1
`define AEB_STAT_CYC    6:4
`define AEB_STAT_SP     10:8
`define AEB_FLAG_C      0
`define AEB_FLAG_Z      1
`define AEB_FLAG_N      2
`define AEB_FLAG_V      3
`define AEB_FLAG_S      4
`define AEB_FLAG_H      5
`define AEB_FLAG_I      7
`define AEB_RST_PC      22'h000000
`define AEB_RST_BYTE    8'h00
`define AEB_RST_Z       16'h0000
`define AEB_CYC_SEQ     3'h1
`define AEB_CYC_SKIP1   3'h2
`define AEB_CYC_SKIP2   3'h3
`define AEB_CYC_BRANCH  3'h2
`define AEB_CYC_JUMP    3'h2
`define AEB_CYC_CALL    3'h3
`define AEB_CYC_RET     3'h4
`define AEB_PC_STEP     22'h000001
`define AEB_PC_SKIP1    22'h000002
`define AEB_PC_SKIP2    22'h000003
`define AEB_STACK_DEPTH 8
`define AEB_RESP_OKAY   2'h0
`define AEB_RESP_SLVERR 2'h2
`endif

//--- core/aeb_pkg.sv
// Types shared by the execution unit modules
// Assumes aeb_defs.svh for all numeric constants
package aeb_pkg;
	typedef enum logic [4:0] {
		OP_ADD = 5'h00, OP_ADD_CARRY = 5'h01, OP_SUB = 5'h02, OP_SUB_IMM = 5'h03,
		OP_SUB_BORROW = 5'h04, OP_SUB_IMM_BORROW = 5'h05, OP_AND = 5'h06, OP_AND_WITH_CONSTANT = 5'h07,
		OP_OR = 5'h08, OP_OR_WITH_CONSTANT = 5'h09, OP_XOR = 5'h0A, OP_ZERO_MINUS_TEST = 5'h0B,
		OP_SET_MASK_BITS = 5'h0C, OP_CLEAR_MASK_BITS = 5'h0D, OP_COMPARE = 5'h0E, OP_COMPARE_CARRY = 5'h0F,
		OP_COMPARE_IMM = 5'h10, OP_COMPARE_SKIP_EQUAL = 5'h11, OP_SKIP_REG_BIT_CLEAR = 5'h12,
		OP_SKIP_REG_BIT_SET = 5'h13, OP_SKIP_IO_BIT_CLEAR = 5'h14, OP_SKIP_IO_BIT_SET = 5'h15,
		OP_BRANCH_FLAG_SET = 5'h16, OP_BRANCH_FLAG_CLEAR = 5'h17, OP_POINTER_JUMP = 5'h18,
		OP_POINTER_CALL = 5'h19, OP_RETURN = 5'h1A, OP_INTERRUPT_RETURN = 5'h1B
	} aeb_op_e;
	typedef enum logic [0:0] {
		AEB_IDLE = 1'h0,
		AEB_RUN  = 1'h1
	} aeb_state_e;
	typedef logic [21:0] aeb_pc_t;
endpackage : aeb_pkg

//--- core/aeb_alu.sv
// Eight-bit arithmetic and logic unit with status flag update
// Assumes operands and flags are stable while the result is used
`timescale 1ns/100ps
`include "aeb_defs.svh"
module aeb_alu
	import aeb_pkg::*;
(
	input  aeb_op_e    op,
	input  logic [7:0] a,
	input  logic [7:0] b,
	input  logic [7:0] flags_in,
	output logic [7:0] result,
	output logic [7:0] flags_out,
	output logic       write_en
);
	logic [8:0] sum;
	logic [7:0] lres;
	logic       arith;
	logic       lgc;
	logic       is_sub;
	logic       use_c;
	logic       keep_z;
	logic       cin;
	always_comb begin
		arith = 1'b0;
		lgc = 1'b0;
		is_sub = 1'b0;
		use_c = 1'b0;
		keep_z = 1'b0;
		write_en = 1'b0;
		lres = a;
		unique case (op)
			OP_ADD: begin arith = 1'b1; write_en = 1'b1; end
			OP_ADD_CARRY: begin arith = 1'b1; use_c = 1'b1; write_en = 1'b1; end
			OP_SUB, OP_SUB_IMM: begin arith = 1'b1; is_sub = 1'b1; write_en = 1'b1; end
			OP_SUB_BORROW, OP_SUB_IMM_BORROW: begin
				arith = 1'b1; is_sub = 1'b1; use_c = 1'b1; keep_z = 1'b1; write_en = 1'b1;
			end
			OP_COMPARE, OP_COMPARE_IMM: begin arith = 1'b1; is_sub = 1'b1; end
			OP_COMPARE_CARRY: begin arith = 1'b1; is_sub = 1'b1; use_c = 1'b1; keep_z = 1'b1; end
			OP_AND, OP_AND_WITH_CONSTANT: begin lgc = 1'b1; lres = a & b; write_en = 1'b1; end
			OP_OR, OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS: begin
				lgc = 1'b1; lres = a | b; write_en = 1'b1;
			end
			OP_XOR: begin lgc = 1'b1; lres = a ^ b; write_en = 1'b1; end
			OP_ZERO_MINUS_TEST: begin lgc = 1'b1; lres = a & a; end
			OP_CLEAR_MASK_BITS: begin lgc = 1'b1; lres = a & ~b; write_en = 1'b1; end
			default: ;
		endcase
		cin = use_c & flags_in[`AEB_FLAG_C];
		if (is_sub)
			sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
		else
			sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		result = arith ? sum[7:0] : lres;
		flags_out = flags_in;
		if (arith) begin
			flags_out[`AEB_FLAG_C] = sum[8];
			if (is_sub) begin
				flags_out[`AEB_FLAG_H] = (~a[3] & b[3]) | (b[3] & result[3]) | (result[3] & ~a[3]);
				flags_out[`AEB_FLAG_V] = (a[7] & ~b[7] & ~result[7]) | (~a[7] & b[7] & result[7]);
			end else begin
				flags_out[`AEB_FLAG_H] = (a[3] & b[3]) | (b[3] & ~result[3]) | (~result[3] & a[3]);
				flags_out[`AEB_FLAG_V] = (a[7] & b[7] & ~result[7]) | (~a[7] & ~b[7] & result[7]);
			end
		end
		if (lgc)
			flags_out[`AEB_FLAG_V] = 1'b0;
		if (arith | lgc) begin
			flags_out[`AEB_FLAG_Z] = (result == 8'h00) & (~keep_z | flags_in[`AEB_FLAG_Z]);
			flags_out[`AEB_FLAG_N] = result[7];
			flags_out[`AEB_FLAG_S] = result[7] ^ flags_out[`AEB_FLAG_V];
		end
	end
endmodule : aeb_alu

//--- core/aeb_flow.sv
// Program counter update and cycle count for skips, branches, jumps, calls and returns
// Assumes the caller holds the stack and commits the outputs at the end of the operation
`timescale 1ns/100ps
`include "aeb_defs.svh"
module aeb_flow
	import aeb_pkg::*;
(
	input  aeb_op_e     op,
	input  aeb_pc_t     pc,
	input  aeb_pc_t     stack_top,
	input  logic [6:0]  k,
	input  logic [2:0]  sel,
	input  logic        two_word,
	input  logic [15:0] zptr,
	input  logic [7:0]  flags,
	input  logic [7:0]  rd,
	input  logic [7:0]  rr,
	input  logic [7:0]  io,
	output aeb_pc_t     pc_next,
	output logic [2:0]  cycles,
	output logic        taken,
	output logic        push,
	output logic        pop,
	output logic        set_ie
);
	logic skip;
	logic branch;
	logic cond;
	always_comb begin
		skip = 1'b0;
		branch = 1'b0;
		cond = 1'b0;
		pc_next = pc + `AEB_PC_STEP;
		cycles = `AEB_CYC_SEQ;
		taken = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		set_ie = 1'b0;
		unique case (op)
			OP_COMPARE_SKIP_EQUAL: begin skip = 1'b1; cond = (rd == rr); end
			OP_SKIP_REG_BIT_CLEAR: begin skip = 1'b1; cond = ~rd[sel]; end
			OP_SKIP_REG_BIT_SET: begin skip = 1'b1; cond = rd[sel]; end
			OP_SKIP_IO_BIT_CLEAR: begin skip = 1'b1; cond = ~io[sel]; end
			OP_SKIP_IO_BIT_SET: begin skip = 1'b1; cond = io[sel]; end
			OP_BRANCH_FLAG_SET: begin branch = 1'b1; cond = flags[sel]; end
			OP_BRANCH_FLAG_CLEAR: begin branch = 1'b1; cond = ~flags[sel]; end
			OP_POINTER_JUMP: begin
				pc_next = {6'h00, zptr}; cycles = `AEB_CYC_JUMP; taken = 1'b1;
			end
			OP_POINTER_CALL: begin
				pc_next = {6'h00, zptr}; cycles = `AEB_CYC_CALL; taken = 1'b1; push = 1'b1;
			end
			OP_RETURN: begin pc_next = stack_top; cycles = `AEB_CYC_RET; taken = 1'b1; pop = 1'b1; end
			OP_INTERRUPT_RETURN: begin
				pc_next = stack_top; cycles = `AEB_CYC_RET; taken = 1'b1; pop = 1'b1; set_ie = 1'b1;
			end
			default: ;
		endcase
		if (skip && cond) begin
			pc_next = pc + (two_word ? `AEB_PC_SKIP2 : `AEB_PC_SKIP1);
			cycles = two_word ? `AEB_CYC_SKIP2 : `AEB_CYC_SKIP1;
			taken = 1'b1;
		end
		if (branch && cond) begin
			pc_next = pc + {{15{k[6]}}, k} + `AEB_PC_STEP;
			cycles = `AEB_CYC_BRANCH;
			taken = 1'b1;
		end
	end
endmodule : aeb_flow

//--- core/aeb_exec.sv
// Execution unit for arithmetic, logic, compare, skip and branch operations with an AXI4-Lite slave
// Assumes one AXI4-Lite master on aclk; an operation starts when its command word is written
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "aeb_defs.svh"
// Overview of operation
// - Subtract immediate with borrow: write back, update all six arithmetic flags, one cycle.
// - AND with constant: write back, update Z N V S, keep C and H.
// - OR with constant: write back, update Z N V S, one cycle.
// - Zero or minus test: value unchanged, update Z N V S, one cycle.
// - Set mask bits: OR with mask, update Z N V S, one cycle.
// - Clear mask bits: AND with inverted mask, update Z N V S.
// - Compare and skip if equal: no write, skip next instruction.
// - Skip when the selected register bit is zero.
// - Skip when the selected register bit is one.
// - Skip when the selected I/O bit is zero, flags untouched.
// - Skip when the selected I/O bit is one, flags untouched.
// - Branch on flag set: PC gets PC plus offset plus one.
// - Branch on flag clear: one cycle not taken, two taken, flags unchanged.
// - Pointer jump: PC low sixteen bits from Z, upper bits cleared, two cycles.
// - Pointer call: push return address, PC from Z, three cycles.
module aeb_exec
	import aeb_pkg::*;
(
	input  logic        aclk,
	input  logic        aresetn,
	input  logic [7:0]  awaddr,
	input  logic        awvalid,
	output logic        awready,
	input  logic [31:0] wdata,
	input  logic [3:0]  wstrb,
	input  logic        wvalid,
	output logic        wready,
	output logic [1:0]  bresp,
	output logic        bvalid,
	input  logic        bready,
	input  logic [7:0]  araddr,
	input  logic        arvalid,
	output logic        arready,
	output logic [31:0] rdata,
	output logic [1:0]  rresp,
	output logic        rvalid,
	input  logic        rready
);
	aeb_state_e  state_reg;
	aeb_op_e     op_reg;
	logic [2:0]  sel_reg;
	logic        two_reg;
	logic [6:0]  k_reg;
	logic [2:0]  cnt_reg;
	logic [7:0]  rd_reg;
	logic [7:0]  rr_reg;
	logic [7:0]  io_reg;
	logic [7:0]  flags_reg;
	logic [15:0] z_reg;
	aeb_pc_t     pc_reg;
	logic [2:0]  sp_reg;
	aeb_pc_t     stack_mem [0:`AEB_STACK_DEPTH-1];
	logic        taken_reg;
	logic [2:0]  last_cyc_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        aw_got_reg;
	logic        w_got_reg;
	logic        wr_fire;
	logic        wr_take;
	logic        commit;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_hit;
	logic [7:0]  alu_res;
	logic [7:0]  alu_flags;
	logic        alu_we;
	aeb_pc_t     fl_pc;
	logic [2:0]  fl_cyc;
	logic        fl_taken;
	logic        fl_push;
	logic        fl_pop;
	logic        fl_set_ie;
	aeb_pc_t     stack_top;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				m[8*i +: 8] = nw[8*i +: 8];
		end
		return m;
	endfunction : merge

	function automatic logic mapped(input logic [7:0] addr);
		logic hit;
		unique case (addr)
			`AEB_OFF_CTRL, `AEB_OFF_OPND, `AEB_OFF_ZPTR, `AEB_OFF_PC, `AEB_OFF_FLAGS, `AEB_OFF_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : mapped

	// Operation units
	aeb_alu u_alu (
		.op        (op_reg),
		.a         (rd_reg),
		.b         (rr_reg),
		.flags_in  (flags_reg),
		.result    (alu_res),
		.flags_out (alu_flags),
		.write_en  (alu_we)
	);

	aeb_flow u_flow (
		.op        (op_reg),
		.pc        (pc_reg),
		.stack_top (stack_top),
		.k         (k_reg),
		.sel       (sel_reg),
		.two_word  (two_reg),
		.zptr      (z_reg),
		.flags     (flags_reg),
		.rd        (rd_reg),
		.rr        (rr_reg),
		.io        (io_reg),
		.pc_next   (fl_pc),
		.cycles    (fl_cyc),
		.taken     (fl_taken),
		.push      (fl_push),
		.pop       (fl_pop),
		.set_ie    (fl_set_ie)
	);

	assign stack_top = stack_mem[sp_reg - 3'h1];
	assign wr_fire = aw_got_reg & w_got_reg & ~bvalid;
	assign wr_take = wr_fire & (state_reg == AEB_IDLE);
	assign wr_hit = mapped(aw_addr_reg);
	assign rd_hit = mapped(araddr);
	assign commit = (state_reg == AEB_RUN) && (cnt_reg == fl_cyc - 3'h1);

	// Write address, data and response channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `AEB_RESP_OKAY;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			if (!aw_got_reg && !bvalid && !awready)
				awready <= 1'b1;
			if (!w_got_reg && !bvalid && !wready)
				wready <= 1'b1;
			if (awvalid && awready) begin
				aw_addr_reg <= awaddr;
				aw_got_reg <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
				w_got_reg <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? `AEB_RESP_OKAY : `AEB_RESP_SLVERR;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// Read data mux
	always_comb begin
		rd_word = 32'h00000000;
		unique case (araddr)
			`AEB_OFF_CTRL: begin
				rd_word[`AEB_CTRL_OP] = op_reg;
				rd_word[`AEB_CTRL_SEL] = sel_reg;
				rd_word[`AEB_CTRL_TWO] = two_reg;
				rd_word[`AEB_CTRL_K] = k_reg;
			end
			`AEB_OFF_OPND: rd_word = {8'h00, io_reg, rr_reg, rd_reg};
			`AEB_OFF_ZPTR: rd_word = {16'h0000, z_reg};
			`AEB_OFF_PC: rd_word = {10'h000, pc_reg};
			`AEB_OFF_FLAGS: rd_word = {24'h000000, flags_reg};
			`AEB_OFF_STAT: begin
				rd_word[`AEB_STAT_BUSY] = (state_reg == AEB_RUN);
				rd_word[`AEB_STAT_TAKEN] = taken_reg;
				rd_word[`AEB_STAT_CYC] = last_cyc_reg;
				rd_word[`AEB_STAT_SP] = sp_reg;
			end
			default: ;
		endcase
	end

	// Read address and data channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `AEB_RESP_OKAY;
		end else begin
			if (!rvalid && !arready)
				arready <= 1'b1;
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= rd_hit ? `AEB_RESP_OKAY : `AEB_RESP_SLVERR;
			end
			if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	// Command capture and cycle sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= AEB_IDLE;
			op_reg <= OP_ADD;
			sel_reg <= 3'h0;
			two_reg <= 1'b0;
			k_reg <= 7'h00;
			cnt_reg <= 3'h0;
			taken_reg <= 1'b0;
			last_cyc_reg <= 3'h0;
		end else if (state_reg == AEB_IDLE) begin
			if (wr_take && aw_addr_reg == `AEB_OFF_CTRL) begin
				state_reg <= AEB_RUN;
				op_reg <= aeb_op_e'(w_data_reg[`AEB_CTRL_OP]);
				sel_reg <= w_data_reg[`AEB_CTRL_SEL];
				two_reg <= w_data_reg[`AEB_CTRL_TWO];
				k_reg <= w_data_reg[`AEB_CTRL_K];
				cnt_reg <= 3'h0;
			end
		end else if (commit) begin
			state_reg <= AEB_IDLE;
			cnt_reg <= 3'h0;
			taken_reg <= fl_taken;
			last_cyc_reg <= fl_cyc;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end

	// Operand, flag and program counter registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_reg <= `AEB_RST_BYTE;
			rr_reg <= `AEB_RST_BYTE;
			io_reg <= `AEB_RST_BYTE;
			flags_reg <= `AEB_RST_BYTE;
			z_reg <= `AEB_RST_Z;
			pc_reg <= `AEB_RST_PC;
		end else if (commit) begin
			if (alu_we)
				rd_reg <= alu_res;
			flags_reg <= alu_flags;
			flags_reg[`AEB_FLAG_I] <= alu_flags[`AEB_FLAG_I] | fl_set_ie;
			pc_reg <= fl_pc;
		end else if (wr_take) begin
			unique case (aw_addr_reg)
				`AEB_OFF_OPND:
					{io_reg, rr_reg, rd_reg} <= 24'(merge({8'h00, io_reg, rr_reg, rd_reg}, w_data_reg, w_strb_reg));
				`AEB_OFF_ZPTR: z_reg <= 16'(merge({16'h0000, z_reg}, w_data_reg, w_strb_reg));
				`AEB_OFF_PC: pc_reg <= aeb_pc_t'(merge({10'h000, pc_reg}, w_data_reg, w_strb_reg));
				`AEB_OFF_FLAGS: flags_reg <= 8'(merge({24'h000000, flags_reg}, w_data_reg, w_strb_reg));
				default: ;
			endcase
		end
	end

	// Return address stack
	always_ff @(posedge aclk) begin
		if (commit && fl_push)
			stack_mem[sp_reg] <= pc_reg + `AEB_PC_STEP;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sp_reg <= 3'h0;
		else if (commit && fl_push)
			sp_reg <= sp_reg + 3'h1;
		else if (commit && fl_pop)
			sp_reg <= sp_reg - 3'h1;
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sub_borrow_result_a: assert property (commit && op_reg == OP_SUB_IMM_BORROW |=>
		rd_reg == $past(rd_reg - rr_reg - {7'h00, flags_reg[`AEB_FLAG_C]}) &&
		flags_reg[`AEB_FLAG_C] == $past({1'b0, rd_reg} < ({1'b0, rr_reg} + {8'h00, flags_reg[`AEB_FLAG_C]})))
		else $error("borrow subtract result or carry wrong");

	and_keeps_ch_a: assert property (commit && op_reg == OP_AND_WITH_CONSTANT |=>
		rd_reg == $past(rd_reg & rr_reg) && flags_reg[`AEB_FLAG_C] == $past(flags_reg[`AEB_FLAG_C]) &&
		flags_reg[`AEB_FLAG_H] == $past(flags_reg[`AEB_FLAG_H]) && !flags_reg[`AEB_FLAG_V])
		else $error("and with constant changed carry or half carry");

	or_mask_result_a: assert property (commit && (op_reg == OP_OR_WITH_CONSTANT || op_reg == OP_SET_MASK_BITS) |=>
		rd_reg == $past(rd_reg | rr_reg) && flags_reg[`AEB_FLAG_Z] == (rd_reg == 8'h00) &&
		flags_reg[`AEB_FLAG_S] == rd_reg[7])
		else $error("or result or flags wrong");

	test_unchanged_a: assert property (commit && op_reg == OP_ZERO_MINUS_TEST |=>
		$stable(rd_reg) && flags_reg[`AEB_FLAG_N] == rd_reg[7] && flags_reg[`AEB_FLAG_Z] == (rd_reg == 8'h00))
		else $error("zero or minus test altered register or flags wrong");

	clear_mask_a: assert property (commit && op_reg == OP_CLEAR_MASK_BITS |=>
		rd_reg == $past(rd_reg & ~rr_reg) && !flags_reg[`AEB_FLAG_V])
		else $error("clear mask result wrong");

	skip_equal_pc_a: assert property (commit && op_reg == OP_COMPARE_SKIP_EQUAL && rd_reg == rr_reg |=>
		pc_reg == $past(pc_reg) + ($past(two_reg) ? `AEB_PC_SKIP2 : `AEB_PC_SKIP1) && $stable(rd_reg) &&
		$stable(flags_reg))
		else $error("compare skip moved program counter wrongly");

	skip_bit_len_a: assert property ($rose(state_reg == AEB_RUN) &&
		(op_reg == OP_SKIP_REG_BIT_CLEAR && !rd_reg[sel_reg] || op_reg == OP_SKIP_REG_BIT_SET && rd_reg[sel_reg]) &&
		two_reg |-> !commit[*2] ##1 commit ##1 pc_reg == $past(pc_reg, 3) + `AEB_PC_SKIP2)
		else $error("register bit skip length wrong");

	io_skip_flags_a: assert property (commit && (op_reg == OP_SKIP_IO_BIT_CLEAR || op_reg == OP_SKIP_IO_BIT_SET) |=>
		$stable(flags_reg) && pc_reg == $past(pc_reg) + (($past(io_reg[sel_reg]) == (op_reg == OP_SKIP_IO_BIT_SET)) ?
		($past(two_reg) ? `AEB_PC_SKIP2 : `AEB_PC_SKIP1) : `AEB_PC_STEP))
		else $error("io bit skip wrong or flags changed");

	branch_set_pc_a: assert property (commit && op_reg == OP_BRANCH_FLAG_SET && flags_reg[sel_reg] |=>
		pc_reg == $past(pc_reg) + {{15{$past(k_reg[6])}}, $past(k_reg)} + `AEB_PC_STEP)
		else $error("branch on flag set target wrong");

	branch_clear_time_a: assert property ($rose(state_reg == AEB_RUN) && op_reg == OP_BRANCH_FLAG_CLEAR |->
		if (flags_reg[sel_reg]) (commit ##1 $stable(flags_reg)) else (!commit ##1 commit ##1 $stable(flags_reg)))
		else $error("branch on flag clear cycle count or flags wrong");

	pointer_jump_a: assert property ($rose(state_reg == AEB_RUN) && op_reg == OP_POINTER_JUMP |->
		!commit ##1 commit ##1 pc_reg == {6'h00, $past(z_reg, 2)} && $stable(flags_reg))
		else $error("pointer jump target or timing wrong");

	pointer_call_a: assert property ($rose(state_reg == AEB_RUN) && op_reg == OP_POINTER_CALL |->
		!commit[*2] ##1 commit ##1 sp_reg == $past(sp_reg) + 3'h1 && pc_reg == {6'h00, z_reg} &&
		stack_mem[$past(sp_reg)] == $past(pc_reg) + `AEB_PC_STEP)
		else $error("pointer call push or timing wrong");

	compare_nowrite_a: assert property (commit && (op_reg == OP_COMPARE || op_reg == OP_COMPARE_IMM) |=>
		$stable(rd_reg) && flags_reg[`AEB_FLAG_Z] == ($past(rd_reg) == $past(rr_reg)))
		else $error("compare wrote destination or zero flag wrong");

	return_flags_a: assert property (commit && (op_reg == OP_RETURN || op_reg == OP_INTERRUPT_RETURN) |=>
		pc_reg == $past(stack_top) && (op_reg == OP_INTERRUPT_RETURN ? flags_reg[`AEB_FLAG_I] : $stable(flags_reg)))
		else $error("return restored wrong address or flags");

	skip_two_word_c: cover property (commit && fl_taken && two_reg && op_reg == OP_COMPARE_SKIP_EQUAL);
	branch_taken_c: cover property (commit && fl_taken && op_reg == OP_BRANCH_FLAG_SET);
	call_return_c: cover property (commit && op_reg == OP_POINTER_CALL ##[1:200] commit && op_reg == OP_INTERRUPT_RETURN);
	borrow_sub_c: cover property (commit && op_reg == OP_SUB_IMM_BORROW && flags_reg[`AEB_FLAG_C]);
endmodule : aeb_exec

//--- dv/aeb_host_model.sv
// AXI4-Lite master standing in for the decoder side of the execution unit
// Assumes aclk from the bench; the bench watchdog ends any hang
`timescale 1ns/100ps
module aeb_host_model (
	input  logic        aclk,
	output logic [7:0]  awaddr,
	output logic        awvalid,
	input  logic        awready,
	output logic [31:0] wdata,
	output logic [3:0]  wstrb,
	output logic        wvalid,
	input  logic        wready,
	input  logic [1:0]  bresp,
	input  logic        bvalid,
	output logic        bready,
	output logic [7:0]  araddr,
	output logic        arvalid,
	input  logic        arready,
	input  logic [31:0] rdata,
	input  logic [1:0]  rresp,
	input  logic        rvalid,
	output logic        rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	// Released payloads flip so a stale value is never mistaken for a held one
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		{awaddr, wdata, wstrb} <= {a, d, 4'hF};
		{awvalid, wvalid, bready} <= 3'b111;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
			if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		{araddr, arvalid, rready} <= {a, 2'b11};
		forever begin
			@(posedge aclk);
			if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
			if (rvalid) break;
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
endmodule : aeb_host_model

//--- dv/alu_and_branch_execution_tb_top.sv
// Self-checking bench for the execution unit, driven over its register bus
// Assumes the host model as bus master and a 200 MHz clock
`timescale 1ns/100ps
`include "aeb_defs.svh"
module alu_and_branch_execution_tb_top;
	import aeb_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          n_fail = 0, n_tests = 0;
	aeb_op_e     lop [5] = '{OP_AND_WITH_CONSTANT, OP_OR_WITH_CONSTANT, OP_ZERO_MINUS_TEST,
		OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS};
	logic [31:0] lin [5] = '{32'h0FF0, 32'h8140, 32'h0080, 32'h0000, 32'h0FFF};
	logic [31:0] lot [5] = '{32'h0F00, 32'h81C1, 32'h0080, 32'h0000, 32'h0FF0};
	logic [7:0]  lfi [5] = '{8'h21, 8'h02, 8'h0A, 8'h1C, 8'h08};
	logic [7:0]  lfo [5] = '{8'h23, 8'h14, 8'h14, 8'h02, 8'h14};
	aeb_exec i_aeb_exec (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	aeb_host_model i_aeb_host_model (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_aeb_host_model.wr(a, v, r);
		chk({30'h0, r}, {30'h0, `AEB_RESP_OKAY});
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		i_aeb_host_model.rd(a, v, r);
		chk({30'h0, r}, {30'h0, `AEB_RESP_OKAY});
	endtask : rd
	function automatic logic [31:0] ctl(aeb_op_e o, logic [2:0] s = 3'h0, logic t = 1'b0, logic [6:0] k = 7'h0);
		return {9'h0, k, 3'h0, t, 1'h0, s, 3'h0, o};
	endfunction : ctl
	// Loads operands, starts one operation, waits out busy and checks every result register
	task automatic ex(input logic [31:0] c, o, input logic [7:0] f, input aeb_pc_t p,
		input logic [31:0] eo, input logic [7:0] ef, input aeb_pc_t ep, input logic [31:0] es, input logic x);
		logic [31:0] v;
		wr(`AEB_OFF_OPND, o);
		wr(`AEB_OFF_FLAGS, {24'h0, f});
		wr(`AEB_OFF_PC, {10'h0, p});
		wr(`AEB_OFF_CTRL, c);
		v = 32'h1;
		for (int i = 0; i < 8 && v[0] !== 1'b0; i++) rd(`AEB_OFF_STAT, v);
		chk(v & ~{30'h0, x, 1'b0}, es);
		rd(`AEB_OFF_OPND, v);
		chk(v, eo);
		rd(`AEB_OFF_FLAGS, v);
		chk(v, {24'h0, ef});
		rd(`AEB_OFF_PC, v);
		chk(v, {10'h0, ep});
	endtask : ex
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		complete_run();
	end
	initial begin
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`AEB_OFF_PC, d);
		chk(d, 32'h0);
		ex(ctl(OP_SUB_IMM_BORROW), 32'h2010, 8'h01, 22'h0, 32'h20EF, 8'h35, 22'h1, 32'h10, 1'b0);
		for (int i = 0; i < 5; i++)
			ex(ctl(lop[i]), lin[i], lfi[i], 22'h0, lot[i], lfo[i], 22'h1, 32'h10, 1'b0);
		ex(ctl(OP_ADD), 32'h010F, 8'h00, 22'h10, 32'h0110, 8'h20, 22'h11, 32'h10, 1'b0);
		ex(ctl(OP_COMPARE), 32'h1010, 8'h01, 22'h10, 32'h1010, 8'h02, 22'h11, 32'h10, 1'b0);
		ex(ctl(OP_COMPARE_SKIP_EQUAL), 32'h5555, 8'h00, 22'h20, 32'h5555, 8'h00, 22'h22, 32'h22, 1'b0);
		ex(ctl(OP_COMPARE_SKIP_EQUAL, 3'h0, 1'b1), 32'h5555, 8'h00, 22'h20, 32'h5555, 8'h00, 22'h23, 32'h32, 1'b0);
		for (int j = 0; j < 4; j++)
			ex(ctl(aeb_op_e'(5'h12 + j[4:0]), 3'h3), 32'h080808, 8'h3F, 22'h40, 32'h080808, 8'h3F,
				j[0] ? 22'h42 : 22'h41, j[0] ? 32'h22 : 32'h10, 1'b0);
		ex(ctl(OP_SKIP_REG_BIT_SET, 3'h3, 1'b1), 32'h080808, 8'h3F, 22'h40, 32'h080808, 8'h3F, 22'h43, 32'h32, 1'b0);
		ex(ctl(OP_BRANCH_FLAG_SET, 3'h1, 1'b0, 7'h7E), 32'h0, 8'h02, 22'h100, 32'h0, 8'h02, 22'hFF, 32'h22, 1'b0);
		ex(ctl(OP_BRANCH_FLAG_CLEAR, 3'h1, 1'b0, 7'h7E), 32'h0, 8'h02, 22'h100, 32'h0, 8'h02, 22'h101, 32'h10, 1'b0);
		ex(ctl(OP_BRANCH_FLAG_CLEAR, 3'h1, 1'b0, 7'h7E), 32'h0, 8'h00, 22'h100, 32'h0, 8'h00, 22'hFF, 32'h22, 1'b0);
		wr(`AEB_OFF_ZPTR, 32'hBEEF);
		ex(ctl(OP_POINTER_JUMP), 32'h0, 8'h00, 22'h3F0000, 32'h0, 8'h00, 22'hBEEF, 32'h22, 1'b0);
		wr(`AEB_OFF_ZPTR, 32'h0200);
		ex(ctl(OP_POINTER_CALL), 32'h0, 8'h00, 22'h123, 32'h0, 8'h00, 22'h200, 32'h130, 1'b1);
		ex(ctl(OP_INTERRUPT_RETURN), 32'h0, 8'h00, 22'h200, 32'h0, 8'h80, 22'h124, 32'h40, 1'b1);
		ex(ctl(OP_POINTER_CALL), 32'h0, 8'h35, 22'h123, 32'h0, 8'h35, 22'h200, 32'h130, 1'b1);
		ex(ctl(OP_RETURN), 32'h0, 8'h35, 22'h200, 32'h0, 8'h35, 22'h124, 32'h40, 1'b1);
		i_aeb_host_model.wr(8'h18, 32'h1, r);
		chk({30'h0, r}, {30'h0, `AEB_RESP_SLVERR});
		i_aeb_host_model.rd(8'h18, d, r);
		chk({d[29:0], r}, {30'h0, `AEB_RESP_SLVERR});
		complete_run();
	end
endmodule : alu_and_branch_execution_tb_top
